// file: inc/scd_pkg.sv
package scd_pkg;

	// Frame geometry, least significant bit shifted first
	localparam int FRAME_BITS = 16;
	localparam logic [4:0] FRAME_BITS_CNT = 5'h10;
	localparam logic [4:0] BIT_CNT_MAX = 5'h1f;
	localparam int MS_LSB = 0;
	localparam int CS_LSB = 3;
	localparam int DATA_LSB = 6;
	localparam logic [4:0] DATA_LSB_CNT = 5'h06;
	localparam int DATA_BITS = 10;
	// Header position inside the receive register once DATA_LSB bits are in
	localparam int EARLY_MS_LSB = FRAME_BITS - DATA_LSB + MS_LSB;
	localparam int EARLY_CS_LSB = FRAME_BITS - DATA_LSB + CS_LSB;

	// Mode selection and register selection codes
	localparam logic [2:0] MODE_READ_ONLY = 3'h3;
	localparam logic [2:0] SEL_CFG = 3'h4;
	localparam logic [2:0] SEL_COMM = 3'h5;
	localparam logic [2:0] SEL_WD = 3'h6;
	localparam logic [2:0] SEL_DIAG = 3'h7;

	// Communication setup fields (frame bit positions)
	localparam int LIN_SLOPE_BIT = 6;
	localparam int CAN_MODE_LSB = 7;
	localparam int LIN_MODE_LSB = 9;
	// Watchdog setup fields
	localparam int WD_PERIOD_LSB = 6;
	localparam int WD_TYPE_BIT = 11;
	localparam int WD_RSVD_BIT = 12;
	localparam int WD_EN_BIT = 13;
	localparam int WD_PARITY_BIT = 14;
	// Configuration fields
	localparam int RT_LSB = 6;
	localparam int LH_ON_BIT = 8;
	localparam int WDFAIL_TO_LIMP_COUNT_BIT = 9;

	// Transceiver cell modes, shared by CAN and LIN
	typedef enum logic [1:0] {
		CELL_OFF = 2'h0,
		CELL_WAKE = 2'h1,
		CELL_RX_ONLY = 2'h2,
		CELL_NORMAL = 2'h3
	} scd_cell_mode_e;

	// Reset values
	localparam logic LIN_SLOPE_RST = 1'h1;
	localparam logic [1:0] CAN_MODE_RST = CELL_OFF;
	localparam logic [1:0] LIN_MODE_RST = CELL_OFF;
	localparam logic WD_TYPE_RST = 1'h1;
	localparam logic WD_EN_RST = 1'h1;
	localparam logic WD_RSVD_VAL = 1'h1;
	localparam logic [4:0] WD_PERIOD_RST = 5'h0f;
	localparam logic [1:0] RT_INVALID = 2'h0;
	localparam logic [1:0] RT_RST = 2'h1;
	localparam logic LH_ON_RST = 1'h0;
	localparam logic WDFAIL_TO_LIMP_COUNT_RST = 1'h1;
	localparam logic [1:0] RC_NONE = 2'h0;
	localparam logic [2:0] LH_NONE = 3'h0;
	localparam logic [2:0] LH_RESERVED = 3'h7;
	localparam logic [1:0] STRAP_SETTLE = 2'h3;

	// Watchdog period arithmetic, milliseconds
	localparam logic [4:0] WD_SPLIT = 5'h10;
	localparam logic [10:0] WD_STEP_LO = 11'h010;
	localparam logic [10:0] WD_STEP_HI = 11'h030;
	localparam logic [10:0] WD_OFFSET_HI = 11'h1d0;

	// Frame tracking states
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_SHIFT = 3'h2,
		ST_DONE = 3'h4
	} scd_frame_state_e;

endpackage

// file: rtl/scd_config_diag.sv
// Operation
// - Selection 101 holds LIN slope bit, reset 1; 1 means low-slope LIN.
// - Two-bit CAN mode, reset 00: off, wake capable, receive only, normal.
// - Two-bit LIN mode, reset 00, same coding as the CAN mode.
// - Selection 110 holds watchdog type and enable, both reset 1.
// - Watchdog write needs parity of bits 13..6, else old setting stays.
// - Selection 111 ignores written data and returns diagnostic fields.
// - Threshold code 01,10,11 selects level; 00 leaves previous threshold.
// - Period code n: (n+1)*16 ms below 16, n*48-464 ms from 16 up; default 15.
// - Restart cause: none, undervoltage, watchdog or wake, flash or external reset.
// - Restart cause clears when read with a read-only command.
// - Restart cause clears when leaving sleep or fail-safe mode.
// - Limp-home cause is a three-bit code of the activation reason.
// - Limp-home cause returns to 000 when host switches limp-home off.
// - Readout 000..011 reports strapped watchdog reaction configuration.
// - Readout 100..111 means development mode: watchdog failure has no effect.
// - Diagnostic encodings apply to shifted-out data only.
// - Host can read strap, test pin and watchdog-to-limp-home setting.
// - Read-only clears selected flags, writes nothing, answers in same frame.
// - Other commands answer the selection during the following frame.
module scd_config_diag (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	input wire logic i_spi_csn_n,
	input wire logic i_spi_sck,
	input wire logic i_spi_sdi,
	output logic o_spi_sdo,
	output logic o_spi_sdo_en_n,
	input wire logic i_strap_int_cfg,
	input wire logic i_test_pin,
	input wire logic i_restart_event,
	input wire logic [1:0] i_restart_code,
	input wire logic i_limp_event,
	input wire logic [2:0] i_limp_code,
	input wire logic i_leave_sleep_fs,
	output logic o_lin_low_slope_select,
	output logic [1:0] o_can_mode,
	output logic [1:0] o_lin_cell_mode_field,
	output logic o_wd_type_select,
	output logic o_wd_enable_bit,
	output logic [4:0] o_wd_period_code,
	output logic [10:0] o_wd_period_ms,
	output logic [1:0] o_reset_threshold_field,
	output logic o_limp_home_on,
	output logic o_wdfail_to_limp_count,
	output logic o_sw_dev_mode,
	output logic o_frame_accept,
	output logic o_read_only,
	output logic o_wd_reject
);

	logic [4:0] sync_out;
	logic csn_s, sck_s, sdi_s, strap_s, test_s;
	logic csn_q, sck_q;
	logic sck_rise, sck_fall, csn_rise, csn_fall;
	scd_pkg::scd_frame_state_e state;
	logic [4:0] bit_cnt;
	logic [15:0] rx;
	logic [15:0] tx;
	logic [2:0] prev_sel;
	logic last_reject;
	logic commit, is_ro, is_write;
	logic [2:0] cmd_ms, cmd_cs;
	logic early_ro;
	logic [2:0] early_cs;
	logic wd_parity_ok;
	logic [4:0] rx_period;
	logic [1:0] rx_rt;
	logic [1:0] restart_cause;
	logic [2:0] limp_cause;
	logic [2:0] strap_readout;
	logic strap_int, strap_test;
	logic [1:0] strap_cnt;

	// Pins are asynchronous to the core clock; chip select idles high
	scd_sync #(.WIDTH(5), .RST_VAL(5'h01)) u_pin_sync (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_clk_en(i_clk_en),
		.i_async({i_test_pin, i_strap_int_cfg, i_spi_sdi, i_spi_sck, i_spi_csn_n}),
		.o_sync(sync_out)
	);
	assign {test_s, strap_s, sdi_s, sck_s, csn_s} = sync_out;

	// Watchdog period decode from the stored code
	scd_wd_period u_wd_period (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_clk_en(i_clk_en),
		.i_code(o_wd_period_code),
		.o_period_ms(o_wd_period_ms)
	);

	// Edge history of the synchronised serial pins
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			csn_q <= 1'h1;
			sck_q <= 1'h0;
		end else if (i_clk_en) begin
			csn_q <= csn_s;
			sck_q <= sck_s;
		end
	end

	// Serial clock edges count only inside a frame
	assign sck_rise = sck_s & ~sck_q & ~csn_s;
	assign sck_fall = ~sck_s & sck_q & ~csn_s;
	assign csn_fall = ~csn_s & csn_q;
	assign csn_rise = csn_s & ~csn_q;

	// Decoded command of a finished frame
	assign commit = (state == scd_pkg::ST_DONE);
	assign cmd_ms = rx[scd_pkg::MS_LSB +: 3];
	assign cmd_cs = rx[scd_pkg::CS_LSB +: 3];
	assign is_ro = (cmd_ms == scd_pkg::MODE_READ_ONLY);
	assign is_write = ~is_ro;
	assign early_ro = (rx[scd_pkg::EARLY_MS_LSB +: 3] == scd_pkg::MODE_READ_ONLY);
	assign early_cs = rx[scd_pkg::EARLY_CS_LSB +: 3];
	assign wd_parity_ok = (rx[scd_pkg::WD_PARITY_BIT] == ^rx[scd_pkg::WD_EN_BIT:scd_pkg::WD_PERIOD_LSB]);
	assign rx_period = rx[scd_pkg::WD_PERIOD_LSB +: 5];
	assign rx_rt = rx[scd_pkg::RT_LSB +: 2];

	// Frame tracking; a frame of the wrong length is dropped at chip select release
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			state <= scd_pkg::ST_IDLE;
		end else if (i_clk_en) begin
			case (state)
				scd_pkg::ST_IDLE: begin
					if (csn_fall) begin
						state <= scd_pkg::ST_SHIFT;
					end
				end
				scd_pkg::ST_SHIFT: begin
					if (csn_rise) begin
						state <= (bit_cnt == scd_pkg::FRAME_BITS_CNT) ? scd_pkg::ST_DONE : scd_pkg::ST_IDLE;
					end
				end
				scd_pkg::ST_DONE: begin
					state <= scd_pkg::ST_IDLE;
				end
				default: begin
					state <= scd_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Receive shifter, sampled on rising serial clock
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			rx <= 16'h0000;
			bit_cnt <= 5'h00;
		end else if (i_clk_en) begin
			if (csn_fall) begin
				bit_cnt <= 5'h00;
			end else if (sck_rise && state == scd_pkg::ST_SHIFT) begin
				rx <= {sdi_s, rx[15:1]};
				// Saturates so overlong frames are never mistaken for full ones
				if (bit_cnt != scd_pkg::BIT_CNT_MAX) begin
					bit_cnt <= bit_cnt + 5'h01;
				end
			end
		end
	end

	// Answer word for a selection; diagnostic codes exist only on this path
	function automatic logic [9:0] read_word(input logic [2:0] sel);
		logic [9:0] w;
		w = 10'h000;
		case (sel)
			scd_pkg::SEL_CFG: w = {6'h00, o_wdfail_to_limp_count, o_limp_home_on, o_reset_threshold_field};
			scd_pkg::SEL_COMM: w = {5'h00, o_lin_cell_mode_field, o_can_mode, o_lin_low_slope_select};
			scd_pkg::SEL_WD: w = {1'h0, ^{o_wd_enable_bit, scd_pkg::WD_RSVD_VAL, o_wd_type_select, o_wd_period_code},
				o_wd_enable_bit, scd_pkg::WD_RSVD_VAL, o_wd_type_select, o_wd_period_code};
			scd_pkg::SEL_DIAG: w = {2'h0, strap_readout, limp_cause, restart_cause};
			default: w = 10'h000;
		endcase
		return w;
	endfunction

	// Transmit shifter; read-only swaps in its own selection after the header
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			tx <= 16'h0000;
		end else if (i_clk_en) begin
			if (csn_fall) begin
				tx <= {read_word(prev_sel), prev_sel, 2'h0, last_reject};
			end else if (sck_fall) begin
				if (bit_cnt == scd_pkg::DATA_LSB_CNT && early_ro) begin
					tx <= {6'h00, read_word(early_cs)};
				end else begin
					tx <= {1'h0, tx[15:1]};
				end
			end
		end
	end

	// Output driver released while chip select is high
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			o_spi_sdo_en_n <= 1'h1;
		end else if (i_clk_en) begin
			o_spi_sdo_en_n <= csn_s;
		end
	end
	assign o_spi_sdo = tx[0];

	// Selection answered by the next frame, and per-frame strobes
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			prev_sel <= scd_pkg::SEL_CFG;
			last_reject <= 1'h0;
			o_frame_accept <= 1'h0;
			o_read_only <= 1'h0;
			o_wd_reject <= 1'h0;
		end else if (i_clk_en) begin
			o_frame_accept <= commit;
			o_read_only <= commit & is_ro;
			o_wd_reject <= commit & is_write & (cmd_cs == scd_pkg::SEL_WD) & ~wd_parity_ok;
			if (commit) begin
				prev_sel <= cmd_cs;
				last_reject <= is_write & (cmd_cs == scd_pkg::SEL_WD) & ~wd_parity_ok;
			end
		end
	end

	// Communication setup register
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			o_lin_low_slope_select <= scd_pkg::LIN_SLOPE_RST;
			o_can_mode <= scd_pkg::CAN_MODE_RST;
			o_lin_cell_mode_field <= scd_pkg::LIN_MODE_RST;
		end else if (i_clk_en && commit && is_write && cmd_cs == scd_pkg::SEL_COMM) begin
			o_lin_low_slope_select <= rx[scd_pkg::LIN_SLOPE_BIT];
			o_can_mode <= rx[scd_pkg::CAN_MODE_LSB +: 2];
			o_lin_cell_mode_field <= rx[scd_pkg::LIN_MODE_LSB +: 2];
		end
	end

	// Watchdog register; reserved bit is not stored, always reads one
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			o_wd_type_select <= scd_pkg::WD_TYPE_RST;
			o_wd_enable_bit <= scd_pkg::WD_EN_RST;
			o_wd_period_code <= scd_pkg::WD_PERIOD_RST;
		end else if (i_clk_en && commit && is_write && cmd_cs == scd_pkg::SEL_WD && wd_parity_ok) begin
			o_wd_type_select <= rx[scd_pkg::WD_TYPE_BIT];
			o_wd_enable_bit <= rx[scd_pkg::WD_EN_BIT];
			o_wd_period_code <= rx_period;
		end
	end

	// Configuration register: threshold, limp-home output, failure count
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			o_reset_threshold_field <= scd_pkg::RT_RST;
			o_limp_home_on <= scd_pkg::LH_ON_RST;
			o_wdfail_to_limp_count <= scd_pkg::WDFAIL_TO_LIMP_COUNT_RST;
		end else if (i_clk_en && commit && is_write && cmd_cs == scd_pkg::SEL_CFG) begin
			// Invalid code would leave the reset comparator undefined
			if (rx_rt != scd_pkg::RT_INVALID) begin
				o_reset_threshold_field <= rx_rt;
			end
			o_limp_home_on <= rx[scd_pkg::LH_ON_BIT];
			o_wdfail_to_limp_count <= rx[scd_pkg::WDFAIL_TO_LIMP_COUNT_BIT];
		end
	end

	// Restart cause; a new event beats a clear in the same cycle
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			restart_cause <= scd_pkg::RC_NONE;
		end else if (i_clk_en) begin
			if (i_restart_event) begin
				restart_cause <= i_restart_code;
			end else if (commit && is_ro && cmd_cs == scd_pkg::SEL_DIAG) begin
				restart_cause <= scd_pkg::RC_NONE;
			end else if (i_leave_sleep_fs) begin
				restart_cause <= scd_pkg::RC_NONE;
			end
		end
	end

	// Limp-home cause; reserved code never stored, set beats clear
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			limp_cause <= scd_pkg::LH_NONE;
		end else if (i_clk_en) begin
			if (i_limp_event && i_limp_code != scd_pkg::LH_RESERVED) begin
				limp_cause <= i_limp_code;
			end else if (commit && is_write && cmd_cs == scd_pkg::SEL_CFG && !rx[scd_pkg::LH_ON_BIT]) begin
				limp_cause <= scd_pkg::LH_NONE;
			end
		end
	end

	// Straps are caught once the synchronisers hold real pin levels
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			strap_cnt <= 2'h0;
			strap_int <= 1'h0;
			strap_test <= 1'h0;
		end else if (i_clk_en && strap_cnt != scd_pkg::STRAP_SETTLE) begin
			strap_cnt <= strap_cnt + 2'h1;
			strap_int <= strap_s;
			strap_test <= test_s;
		end
	end

	// Test pin on top selects development mode, then count, then strap
	assign strap_readout = {strap_test, o_wdfail_to_limp_count, strap_int};
	assign o_sw_dev_mode = strap_readout[2];

	// Checks
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_rst_n);

	a_reset_defaults: assert property ($rose(i_rst_n) |-> o_lin_low_slope_select && o_can_mode == 2'h0 &&
		o_lin_cell_mode_field == 2'h0 && o_wd_type_select && o_wd_enable_bit && o_wd_period_code == 5'h0f)
		else $error("settings not at defaults after reset");

	a_wd_parity_hold: assert property (commit && is_write && cmd_cs == 3'h6 && !wd_parity_ok |=>
		$stable(o_wd_period_code) && $stable(o_wd_enable_bit) && $stable(o_wd_type_select))
		else $error("watchdog changed despite bad parity");

	a_wd_write_takes: assert property (i_clk_en && commit && is_write && cmd_cs == 3'h6 && wd_parity_ok |=>
		o_wd_period_code == $past(rx_period) ##1 o_wd_reject == 1'h0)
		else $error("valid watchdog write not stored");

	a_thr_invalid_hold: assert property (commit && is_write && cmd_cs == 3'h4 && rx_rt == 2'h0 |=>
		$stable(o_reset_threshold_field))
		else $error("invalid threshold code changed threshold");

	a_thr_never_zero: assert property (o_reset_threshold_field != 2'h0)
		else $error("threshold field holds invalid code");

	a_partial_dropped: assert property (i_clk_en && state == scd_pkg::ST_SHIFT && csn_rise && bit_cnt != 5'h10 |=>
		state == scd_pkg::ST_IDLE ##1 !o_frame_accept)
		else $error("partial frame was accepted");

	a_rc_clear_read: assert property (i_clk_en && commit && is_ro && cmd_cs == 3'h7 && !i_restart_event |=>
		restart_cause == 2'h0)
		else $error("restart cause not cleared by read-only");

	a_rc_set_wins: assert property (i_clk_en && i_restart_event |=> restart_cause == $past(i_restart_code))
		else $error("restart event lost");

	a_lh_clear_off: assert property (i_clk_en && commit && is_write && cmd_cs == 3'h4 && !rx[8] && !i_limp_event |=>
		limp_cause == 3'h0 && !o_limp_home_on)
		else $error("limp cause not cleared on limp-home off");

	a_ro_no_write: assert property (commit && is_ro |=> $stable(o_can_mode) && $stable(o_limp_home_on) &&
		$stable(o_reset_threshold_field))
		else $error("read-only command changed a setting");

endmodule // scd_config_diag

// file: rtl/scd_sync.sv
module scd_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta;

	// Two stages; only the second stage reads the first
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			meta <= RST_VAL;
			o_sync <= RST_VAL;
		end else if (i_clk_en) begin
			meta <= i_async;
			o_sync <= meta;
		end
	end

endmodule // scd_sync

// file: rtl/scd_wd_period.sv
module scd_wd_period (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	input wire logic [4:0] i_code,
	output logic [10:0] o_period_ms
);

	logic [10:0] code_w;
	logic [10:0] next_period_ms;

	// Two linear segments, the second starting at the split code
	assign code_w = {6'h00, i_code};
	assign next_period_ms = (i_code < scd_pkg::WD_SPLIT) ?
		(code_w + 11'h001) * scd_pkg::WD_STEP_LO :
		code_w * scd_pkg::WD_STEP_HI - scd_pkg::WD_OFFSET_HI;

	// Registered so the period is a clean data output
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			o_period_ms <= 11'h100;
		end else if (i_clk_en) begin
			o_period_ms <= next_period_ms;
		end
	end

	a_period_formula: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		i_clk_en |=> o_period_ms == (($past(i_code) < 5'h10) ? ({6'h00, $past(i_code)} + 11'h001) * 11'h010 :
			{6'h00, $past(i_code)} * 11'h030 - 11'h1d0))
		else $error("watchdog period does not match its code");

endmodule // scd_wd_period

// file: sim/scd_config_diag_tb_top.sv
module scd_config_diag_tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	localparam logic [2:0] WR = 3'h0;
	localparam logic [2:0] RO = scd_pkg::MODE_READ_ONLY;

	logic i_clock = 1'b0;
	logic i_rst_n = 1'b0;
	logic csn_n, sck, sdi, sdo, sdo_en_n;
	logic rs_ev = 1'b0, lh_ev = 1'b0, leave = 1'b0;
	logic [1:0] rs_code = 2'h0;
	logic strap = 1'b1, tpin = 1'b1;
	logic [2:0] lh_code = 3'h0;
	logic slope, type_sel, wd_en, lh_on, to_limp, dev, acc, ro, rej;
	logic [1:0] can, lin, thr;
	logic [4:0] code;
	logic [10:0] ms;
	int error_cnt = 0, tests_run = 0, acc_cnt = 0, ro_cnt = 0, rej_cnt = 0, cyc = 0;
	logic [15:0] rx;

	always #4 i_clock = ~i_clock;

	scd_config_diag uut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_clk_en(1'b1), .i_spi_csn_n(csn_n),
		.i_spi_sck(sck), .i_spi_sdi(sdi), .o_spi_sdo(sdo), .o_spi_sdo_en_n(sdo_en_n),
		.i_strap_int_cfg(strap), .i_test_pin(tpin), .i_restart_event(rs_ev), .i_restart_code(rs_code),
		.i_limp_event(lh_ev), .i_limp_code(lh_code), .i_leave_sleep_fs(leave),
		.o_lin_low_slope_select(slope), .o_can_mode(can), .o_lin_cell_mode_field(lin),
		.o_wd_type_select(type_sel), .o_wd_enable_bit(wd_en), .o_wd_period_code(code),
		.o_wd_period_ms(ms), .o_reset_threshold_field(thr), .o_limp_home_on(lh_on),
		.o_wdfail_to_limp_count(to_limp), .o_sw_dev_mode(dev), .o_frame_accept(acc),
		.o_read_only(ro), .o_wd_reject(rej));

	scd_host_model host (.i_clock(i_clock), .i_spi_sdo(sdo), .i_spi_sdo_en_n(sdo_en_n),
		.o_spi_csn_n(csn_n), .o_spi_sck(sck), .o_spi_sdi(sdi));

	// Strobe counters and hang guard; a run needs about 4300 cycles
	always @(posedge i_clock) begin
		cyc++;
		if (acc === 1'b1) acc_cnt++;
		if (ro === 1'b1) ro_cnt++;
		if (rej === 1'b1) rej_cnt++;
		if (cyc == 20000) begin
			error_cnt++;
			summarize();
		end
	end

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	function automatic logic [15:0] fr(input logic [2:0] mode, input logic [2:0] sel, input logic [9:0] d);
		return {d, sel, mode};
	endfunction

	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic test_defaults(input logic exp_dev);
		check("slope", 16'(slope), 16'h0001);
		check("can", 16'(can), 16'h0000);
		check("lin", 16'(lin), 16'h0000);
		check("wd type en", 16'({type_sel, wd_en}), 16'h0003);
		check("period", 16'(code), 16'h000f);
		check("period ms", 16'(ms), 16'h0100);
		check("threshold", 16'(thr), 16'h0001);
		check("dev mode", 16'(dev), 16'(exp_dev));
	endtask

	// Every cell mode for both transceivers, answer in the next frame
	task automatic test_comm();
		logic [4:0] d, prev;
		for (int i = 0; i < 4; i++) begin
			d = {2'(3 - i), 2'(i), 1'(i)};
			host.xfer(fr(WR, scd_pkg::SEL_COMM, {5'h00, d}), 16, 1'b0, rx);
			check("can", 16'(can), 16'(i));
			check("lin", 16'(lin), 16'(3 - i));
			check("slope", 16'(slope), 16'(i % 2));
			if (i > 0) check("echo", 16'(rx[10:3]), 16'({prev, 3'h5}));
			prev = d;
		end
		host.xfer(fr(RO, scd_pkg::SEL_COMM, 10'h000), 16, 1'b0, rx);
		check("ro echo", 16'(rx[10:3]), 16'({prev, 3'h5}));
	endtask

	// Period decode at codes 31, 16 and 0, then a bad checksum
	task automatic test_wd();
		logic [4:0] n;
		int exp;
		for (int i = 0; i < 3; i++) begin
			n = (i == 0) ? 5'h1f : (i == 1) ? 5'h10 : 5'h00;
			exp = (n < 16) ? (n + 1) * 16 : n * 48 - 464;
			host.xfer(fr(WR, scd_pkg::SEL_WD, {2'h0, 1'(i), 1'b1, 1'(i), n}), 16, 1'b0, rx);
			check("period", 16'(code), 16'(n));
			check("period ms", 16'(ms), 16'(exp));
			check("wd type en", 16'({type_sel, wd_en}), 16'({1'(i), 1'(i)}));
		end
		exp = rej_cnt;
		host.xfer(fr(WR, scd_pkg::SEL_WD, {2'h0, 1'b1, 1'b1, 1'b1, 5'h05}), 16, 1'b1, rx);
		check("kept period", 16'(code), 16'h0000);
		check("kept type en", 16'({type_sel, wd_en}), 16'h0000);
		check("reject pulse", 16'(rej_cnt - exp), 16'h0001);
		host.xfer(fr(RO, scd_pkg::SEL_WD, 10'h000), 16, 1'b0, rx);
		check("reject flag", 16'(rx[0]), 16'h0001);
		check("reserved", 16'(rx[12]), 16'h0001);
	endtask

	task automatic test_thr();
		host.xfer(fr(WR, scd_pkg::SEL_CFG, 10'h00b), 16, 1'b0, rx);
		check("threshold 3", 16'(thr), 16'h0003);
		host.xfer(fr(WR, scd_pkg::SEL_CFG, 10'h00e), 16, 1'b0, rx);
		check("threshold 2", 16'(thr), 16'h0002);
		host.xfer(fr(WR, scd_pkg::SEL_CFG, 10'h008), 16, 1'b0, rx);
		check("threshold kept", 16'(thr), 16'h0002);
		check("to limp", 16'({to_limp, lh_on}), 16'h0002);
	endtask

	// Short frames and writes to the diagnosis place change nothing
	task automatic test_partial();
		int a;
		a = acc_cnt;
		host.xfer(fr(WR, scd_pkg::SEL_COMM, 10'h01f), 8, 1'b0, rx);
		host.xfer(fr(WR, scd_pkg::SEL_COMM, 10'h01f), 15, 1'b0, rx);
		check("no accept", 16'(acc_cnt - a), 16'h0000);
		check("can kept", 16'({lin, can, slope}), 16'h0007);
		host.xfer(fr(WR, scd_pkg::SEL_DIAG, 10'h3ff), 16, 1'b0, rx);
		check("diag write", 16'({lin, can, slope, thr}), 16'h001e);
		check("full accept", 16'(acc_cnt - a), 16'h0001);
	endtask

	task automatic pulse(input logic [1:0] rc, input logic [2:0] lc, input logic lv);
		rs_ev = (rc != 2'h0);
		rs_code = rc;
		lh_ev = (lc != 3'h0);
		lh_code = lc;
		leave = lv;
		@(posedge i_clock);
		#1;
		rs_ev = 1'b0;
		lh_ev = 1'b0;
		leave = 1'b0;
	endtask

	task automatic test_diag();
		int r;
		r = ro_cnt;
		pulse(2'h2, 3'h5, 1'b0);
		host.xfer(fr(RO, scd_pkg::SEL_DIAG, 10'h000), 16, 1'b0, rx);
		check("restart", 16'(rx[7:6]), 16'h0002);
		check("limp", 16'(rx[10:8]), 16'h0005);
		check("readout", 16'(rx[13:11]), 16'h0007);
		check("ro pulse", 16'(ro_cnt - r), 16'h0001);
		host.xfer(fr(RO, scd_pkg::SEL_DIAG, 10'h000), 16, 1'b0, rx);
		check("restart read clear", 16'(rx[7:6]), 16'h0000);
		pulse(2'h3, 3'h0, 1'b0);
		pulse(2'h0, 3'h0, 1'b1);
		host.xfer(fr(RO, scd_pkg::SEL_DIAG, 10'h000), 16, 1'b0, rx);
		check("restart leave clear", 16'(rx[7:6]), 16'h0000);
		check("limp held", 16'(rx[10:8]), 16'h0005);
		host.xfer(fr(WR, scd_pkg::SEL_CFG, 10'h009), 16, 1'b0, rx);
		// Reserved limp code must not be stored
		pulse(2'h0, 3'h7, 1'b0);
		host.xfer(fr(RO, scd_pkg::SEL_DIAG, 10'h000), 16, 1'b0, rx);
		check("limp off clear", 16'(rx[10:8]), 16'h0000);
	endtask

	// Mid-run reset with both straps low; first answer shows the default selection
	task automatic test_strap();
		i_rst_n = 1'b0;
		strap = 1'b0;
		tpin = 1'b0;
		repeat (2) @(posedge i_clock);
		#1;
		i_rst_n = 1'b1;
		repeat (6) @(posedge i_clock);
		#1;
		test_defaults(1'b0);
		host.xfer(fr(RO, scd_pkg::SEL_DIAG, 10'h000), 16, 1'b0, rx);
		check("first sel", 16'(rx[5:3]), 16'h0004);
		check("readout 2", 16'(rx[13:11]), 16'h0002);
		host.xfer(fr(WR, scd_pkg::SEL_CFG, 10'h001), 16, 1'b0, rx);
		host.xfer(fr(RO, scd_pkg::SEL_DIAG, 10'h000), 16, 1'b0, rx);
		check("readout 0", 16'(rx[13:11]), 16'h0000);
	endtask

	// Reset for two cycles, then let the straps settle before any frame
	initial begin
		repeat (2) @(posedge i_clock);
		#1;
		i_rst_n = 1'b1;
		repeat (6) @(posedge i_clock);
		#1;
		test_defaults(1'b1);
		test_comm();
		test_wd();
		test_thr();
		test_partial();
		test_diag();
		test_strap();
		summarize();
	end
endmodule // scd_config_diag_tb_top

// file: sim/scd_host_model.sv
// Host controller acting as the frame master on the serial link
module scd_host_model (
	input wire logic i_clock,
	input wire logic i_spi_sdo,
	input wire logic i_spi_sdo_en_n,
	output logic o_spi_csn_n,
	output logic o_spi_sck,
	output logic o_spi_sdi
);
	timeunit 1ns;
	timeprecision 100ps;

	// Idle link: select high, clock low, data pulled down
	initial begin
		o_spi_csn_n = 1'b1;
		o_spi_sck = 1'b0;
		o_spi_sdi = 1'b0;
	end

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask

	// Five core cycles per level keeps well above the synchroniser margin
	task automatic xfer(input logic [15:0] tx, input int nbits, input logic bad_par, output logic [15:0] rx);
		logic [15:0] f;
		f = tx;
		rx = '0;
		if (f[2:0] != scd_pkg::MODE_READ_ONLY && f[5:3] == scd_pkg::SEL_WD) begin
			f[scd_pkg::WD_RSVD_BIT] = 1'b1;
			f[scd_pkg::WD_PARITY_BIT] = (^f[13:6]) ^ bad_par;
		end
		wait_cyc(1);
		o_spi_csn_n = 1'b0;
		wait_cyc(5);
		for (int i = 0; i < nbits; i++) begin
			o_spi_sdi = f[i];
			wait_cyc(5);
			// An undriven output line must never pass as data
			rx[i] = (i_spi_sdo_en_n === 1'b0) ? i_spi_sdo : 1'bx;
			o_spi_sck = 1'b1;
			wait_cyc(5);
			o_spi_sck = 1'b0;
		end
		wait_cyc(5);
		o_spi_csn_n = 1'b1;
		o_spi_sdi = 1'b0;
		wait_cyc(10);
	endtask
endmodule // scd_host_model
